// file: common/phyt_pkg.sv
// constants shared by the mii phy timing block
package phyt_pkg;
  localparam int SYS_PERIOD_NS = 8;
  localparam int NIB_PERIOD_100_NS = 40;
  localparam int NIB_PERIOD_10_NS = 400;
  localparam int BIT_TIME_100_NS = 10;
  localparam int BIT_TIME_10_NS = 100;
  localparam int DIV_W = 6;
  localparam int DIV_100 = NIB_PERIOD_100_NS / SYS_PERIOD_NS;
  localparam int DIV_10 = NIB_PERIOD_10_NS / SYS_PERIOD_NS;
  localparam logic [DIV_W-1:0] DIV_100_C = DIV_W'(DIV_100);
  localparam logic [DIV_W-1:0] DIV_10_C = DIV_W'(DIV_10);
  // 2 of 5 cycles high gives 40 percent duty at the fast rate
  localparam logic [DIV_W-1:0] HIGH_100_C = DIV_W'(DIV_100 / 2);
  localparam logic [DIV_W-1:0] HIGH_10_C = DIV_W'(DIV_10 / 2);
  localparam logic [DIV_W-1:0] DIV_RST = 6'h00;
  localparam int NIB_W = 4;
  localparam int FIFO_DEPTH = 4;
  localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
endpackage

// file: design/phyt_mii_phy.sv
// mii side of a 10/100 phy: nibble clocks, transmit path, carrier echo, receive path
//
// Summary of operation
// RQ1: the reference clock from outside runs at 40 ns with 45 to 55 percent duty; this block is clocked from an 8 ns system clock instead.
// RQ2: transmit clock period is 40 ns fast, 400 ns slow, duty 35 to 65 percent.
// RQ3: receive clock period is 40 ns fast, 400 ns slow, duty 35 to 65 percent.
// RQ4: the management clock from outside is at least 400 ns, each phase 160 ns.
// RQ5: at 10 Mb/s a line nibble reaches the receive data within 7 bit times.
// RQ6: at 10 Mb/s a sampled transmit nibble reaches the line within 2 bit times.
// RQ7: at 100 Mb/s the start of stream reaches the line within 3 bit times.
// RQ8: half duplex 100 Mb/s: carrier sense rises within 4 bit times of transmit enable.
// RQ9: half duplex 100 Mb/s: carrier sense falls within 4 bit times of enable low.
// RQ10: bit time is 10 or 100 ns; one nibble per rising mii clock edge.
`timescale 1ns/1ps

module phyt_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_C = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != FULL_C);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    push = in_valid_i & in_ready_o;
    pop = out_valid_o & out_ready_i;
    wr_d = push ? wr_q + PW'(1) : wr_q;
    rd_d = pop ? rd_q + PW'(1) : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset; nothing reads a word before it is written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

module phyt_mii_phy (
  // clocks and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic LINE_CLK_I,
  // mode straps, asynchronous levels
  input wire logic SPEED_100_I,
  input wire logic FULL_DUPLEX_I,
  // mii transmit
  output logic TX_CLK_O,
  input wire logic TX_EN_I,
  input wire logic [3:0] TXD_I,
  // mii receive and carrier
  output logic RX_CLK_O,
  output logic RX_DV_O,
  output logic [3:0] RXD_O,
  output logic CRS_O,
  // line transmit
  output logic TWISTED_PAIR_TRANSMIT_EN_O,
  output logic [3:0] TWISTED_PAIR_TRANSMIT_O,
  // line receive, on the link clock
  input wire logic TWISTED_PAIR_RECEIVE_VALID_I,
  input wire logic [3:0] TWISTED_PAIR_RECEIVE_I,
  output logic TWISTED_PAIR_RECEIVE_READY_O
);
  localparam int NW = phyt_pkg::NIB_W;

  // link domain: hold a nibble and toggle a request
  logic lk_req_q, lk_req_d;
  logic [NW-1:0] lk_data_q, lk_data_d;
  logic lk_ack_s1_q, lk_ack_s2_q;
  logic lk_busy, lk_take;
  logic ack_q, ack_d;

  always_comb begin
    lk_busy = lk_req_q ^ lk_ack_s2_q;
    lk_take = TWISTED_PAIR_RECEIVE_VALID_I & ~lk_busy;
    lk_req_d = lk_req_q ^ lk_take;
    lk_data_d = lk_take ? TWISTED_PAIR_RECEIVE_I : lk_data_q;
  end

  // a full fifo withholds the ack, which holds ready low on the line side
  assign TWISTED_PAIR_RECEIVE_READY_O = ~lk_busy;

  always_ff @(posedge LINE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lk_req_q <= 1'b0;
      lk_data_q <= phyt_pkg::NIB_RST;
      lk_ack_s1_q <= 1'b0;
      lk_ack_s2_q <= 1'b0;
    end else begin
      lk_req_q <= lk_req_d;
      lk_data_q <= lk_data_d;
      lk_ack_s1_q <= ack_q;
      lk_ack_s2_q <= lk_ack_s1_q;
    end
  end

  // system domain: synchronisers for straps and the request toggle
  logic spd_s1_q, spd_q, fdx_s1_q, fdx_q;
  logic req_s1_q, req_s2_q;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      spd_s1_q <= 1'b0;
      spd_q <= 1'b0;
      fdx_s1_q <= 1'b0;
      fdx_q <= 1'b0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      spd_s1_q <= SPEED_100_I;
      spd_q <= spd_s1_q;
      fdx_s1_q <= FULL_DUPLEX_I;
      fdx_q <= fdx_s1_q;
      req_s1_q <= lk_req_q;
      req_s2_q <= req_s1_q;
    end
  end

  // nibble clock divider shared by transmit and receive clocks
  logic [phyt_pkg::DIV_W-1:0] div_q, div_d, per, high;
  logic nib_clk_q, nib_clk_d, tick;

  always_comb begin
    per = spd_q ? phyt_pkg::DIV_100_C : phyt_pkg::DIV_10_C;
    high = spd_q ? phyt_pkg::HIGH_100_C : phyt_pkg::HIGH_10_C;
    // >= keeps a speed change mid period from running the count past the end
    tick = (div_q >= per - phyt_pkg::DIV_W'(1)); // [RQ10]
    div_d = tick ? phyt_pkg::DIV_RST : div_q + phyt_pkg::DIV_W'(1); // [RQ2] [RQ3]
    // rising only on the wrap keeps reset or a strap change from making a short high phase
    nib_clk_d = (div_d < high) && (nib_clk_q || tick); // [RQ2] [RQ3]
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      div_q <= phyt_pkg::DIV_RST;
      nib_clk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      nib_clk_q <= nib_clk_d;
    end
  end

  assign TX_CLK_O = nib_clk_q;
  assign RX_CLK_O = nib_clk_q;

  // transmit path and carrier echo, sampled as the nibble clock rises
  logic tp_en_q, tp_en_d, crs_tx_q, crs_tx_d;
  logic [NW-1:0] tp_data_q, tp_data_d;

  always_comb begin
    tp_en_d = tp_en_q;
    tp_data_d = tp_data_q;
    crs_tx_d = crs_tx_q;
    if (tick) begin
      tp_en_d = TX_EN_I; // [RQ6] [RQ7] [RQ10]
      tp_data_d = TX_EN_I ? TXD_I : phyt_pkg::NIB_RST; // [RQ6] [RQ7]
      crs_tx_d = TX_EN_I & ~fdx_q; // [RQ8] [RQ9]
    end
  end

  // receive path: toggle handshake into the fifo, drained once per nibble clock
  logic push_ok, pend, ff_valid;
  logic [NW-1:0] ff_data;
  logic rx_dv_q, rx_dv_d, crs_q, crs_d;
  logic [NW-1:0] rxd_q, rxd_d;

  always_comb begin
    pend = req_s2_q ^ ack_q;
    ack_d = ack_q ^ (pend & push_ok); // [RQ5]
    rx_dv_d = tick ? ff_valid : rx_dv_q; // [RQ5] [RQ10]
    rxd_d = rxd_q;
    if (tick) begin
      rxd_d = ff_valid ? ff_data : phyt_pkg::NIB_RST; // [RQ5]
    end
    // full duplex shows only receive activity on carrier sense
    crs_d = crs_tx_d | rx_dv_d; // [RQ8] [RQ9]
  end

  phyt_fifo #(
    .WIDTH(NW),
    .DEPTH(phyt_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESET_N_I),
    .in_valid_i(pend),
    .in_ready_o(push_ok),
    .in_data_i(lk_data_q),
    .out_valid_o(ff_valid),
    .out_ready_i(tick),
    .out_data_o(ff_data)
  );

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tp_en_q <= 1'b0;
      tp_data_q <= phyt_pkg::NIB_RST;
      crs_tx_q <= 1'b0;
      ack_q <= 1'b0;
      rx_dv_q <= 1'b0;
      rxd_q <= phyt_pkg::NIB_RST;
      crs_q <= 1'b0;
    end else begin
      tp_en_q <= tp_en_d;
      tp_data_q <= tp_data_d;
      crs_tx_q <= crs_tx_d;
      ack_q <= ack_d;
      rx_dv_q <= rx_dv_d;
      rxd_q <= rxd_d;
      crs_q <= crs_d;
    end
  end

  assign TWISTED_PAIR_TRANSMIT_EN_O = tp_en_q;
  assign TWISTED_PAIR_TRANSMIT_O = tp_data_q;
  assign RX_DV_O = rx_dv_q;
  assign RXD_O = rxd_q;
  assign CRS_O = crs_q;

  // checks, all on the system clock
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_fast_rise;
    $rose(nib_clk_q) && spd_q;
  endsequence

  // high phase length for the slow clock check; a strap change spoils the phase
  logic [phyt_pkg::DIV_W-1:0] hi_cnt_q, hi_cnt_d;
  logic slow_ok_q, slow_ok_d;

  always_comb begin
    hi_cnt_d = nib_clk_q ? hi_cnt_q + phyt_pkg::DIV_W'(1) : phyt_pkg::DIV_RST;
    slow_ok_d = nib_clk_q ? (slow_ok_q & ~spd_q) : 1'b1;
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hi_cnt_q <= phyt_pkg::DIV_RST;
      slow_ok_q <= 1'b0;
    end else begin
      hi_cnt_q <= hi_cnt_d;
      slow_ok_q <= slow_ok_d;
    end
  end

  sequence s_slow_fall;
    $fell(nib_clk_q) && !spd_q && slow_ok_q;
  endsequence

  a_fast_clk_period: assert property ( // [RQ2]
    s_fast_rise ##1 spd_q [*4] |-> ##1 $rose(nib_clk_q))
    else $error("fast nibble clock period is not 5 cycles");

  a_fast_clk_duty: assert property ( // [RQ2]
    s_fast_rise |-> nib_clk_q [*2] ##1 !nib_clk_q)
    else $error("fast nibble clock high phase is not 2 cycles");

  a_slow_clk_half: assert property ( // [RQ3]
    s_slow_fall |-> (hi_cnt_q == phyt_pkg::HIGH_10_C))
    else $error("slow nibble clock high phase is not 25 cycles");

  a_tx_to_line: assert property ( // [RQ7]
    (tick && TX_EN_I) |=> tp_en_q && (tp_data_q == $past(TXD_I)))
    else $error("sampled nibble did not reach the line next cycle");

  a_crs_rise_echo: assert property ( // [RQ8]
    (tick && TX_EN_I && spd_q && !fdx_q) |=> CRS_O)
    else $error("carrier sense did not follow transmit enable");

  a_crs_fall_echo: assert property ( // [RQ9]
    (tick && !TX_EN_I && !ff_valid && spd_q) |=> !CRS_O)
    else $error("carrier sense did not drop after transmit enable");

  a_rx_nibble_out: assert property ( // [RQ5]
    (tick && ff_valid) |=> RX_DV_O && (RXD_O == $past(ff_data)))
    else $error("queued nibble not presented on the next clock rise");

  a_rx_push_ack: assert property ( // [RQ5]
    (pend && push_ok) |=> !pend ##1 !pend)
    else $error("pending line nibble was not taken into the fifo");
endmodule

// file: verification/phyt_mac_model.sv
// mac-side partner model: feeds transmit nibbles and collects received ones
`timescale 1ns/1ps
module phyt_mac_model (
  // clocks
  input wire logic clk_i,
  input wire logic tx_clk_i,
  input wire logic rx_clk_i,
  // receive side of the mii
  input wire logic rx_dv_i,
  input wire logic [3:0] rxd_i,
  // transmit side of the mii
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  logic [3:0] tx_q[$];
  logic [3:0] rx_q[$];
  realtime rx_t;
  logic tx_l = 1'b0;
  logic rx_l = 1'b0;
  initial begin
    tx_en_o = 1'b0;
    txd_o = 4'h0;
  end
  // changes half a sys cycle after each rise, so the next rise samples it
  always @(negedge clk_i) begin
    if (tx_clk_i && !tx_l) begin
      if (tx_q.size() > 0) begin
        tx_en_o <= 1'b1;
        txd_o <= tx_q.pop_front();
      end else begin
        // idle data lines toggle so a stale nibble never looks valid
        tx_en_o <= 1'b0;
        txd_o <= ~txd_o;
      end
    end
    if (rx_clk_i && !rx_l && rx_dv_i) begin
      if (rx_q.size() == 0) begin
        rx_t = $realtime;
      end
      rx_q.push_back(rxd_i);
    end
    tx_l <= tx_clk_i;
    rx_l <= rx_clk_i;
  end
endmodule

// file: verification/phyt_mii_phy_test.sv
// self-checking bench for the mii phy timing block
`timescale 1ns/1ps
module phyt_mii_phy_test;
  logic sys_clk = 1'b0;
  logic line_clk = 1'b0;
  logic rst_n = 1'b0;
  logic spd = 1'b0;
  logic fdx = 1'b0;
  logic lv = 1'b0;
  logic [3:0] ld = 4'h0;
  logic last_tx = 1'b0;
  logic rose = 1'b0;
  logic tx_en, tx_clk, rx_clk, rx_dv, crs, tp_en, rdy;
  logic [3:0] txd, rxd, tp_d;
  realtime t_take;
  int bad_count = 0;
  int tests_run = 0;
  // sys clock runs at the 8 ns system period, not the 40 ns reference
  always #4 sys_clk = ~sys_clk;
  always #62.5 line_clk = ~line_clk;
  phyt_mii_phy u_dut (.SYS_CLK_I(sys_clk), .RESET_N_I(rst_n), .LINE_CLK_I(line_clk),
    .SPEED_100_I(spd), .FULL_DUPLEX_I(fdx), .TX_CLK_O(tx_clk), .TX_EN_I(tx_en),
    .TXD_I(txd), .RX_CLK_O(rx_clk), .RX_DV_O(rx_dv), .RXD_O(rxd), .CRS_O(crs),
    .TWISTED_PAIR_TRANSMIT_EN_O(tp_en), .TWISTED_PAIR_TRANSMIT_O(tp_d),
    .TWISTED_PAIR_RECEIVE_VALID_I(lv), .TWISTED_PAIR_RECEIVE_I(ld),
    .TWISTED_PAIR_RECEIVE_READY_O(rdy));
  phyt_mac_model u_mac (.clk_i(sys_clk), .tx_clk_i(tx_clk), .rx_clk_i(rx_clk),
    .rx_dv_i(rx_dv), .rxd_i(rxd), .tx_en_o(tx_en), .txd_o(txd));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      final_report();
    end
  endtask
  // sample just after the edge, once its updates have landed
  task automatic tick();
    @(posedge sys_clk);
    #1;
    rose = (tx_clk === 1'b1) && (last_tx === 1'b0);
    last_tx = tx_clk;
  endtask
  task automatic next_rise();
    int n;
    n = 0;
    tick();
    while (!rose) begin
      n++;
      hang(n, 200);
      tick();
    end
  endtask
  // straps pass a two-stage sync, so give them a few nibble clocks
  task automatic set_mode(input logic s, input logic f);
    @(negedge sys_clk);
    spd = s;
    fdx = f;
    repeat (3) next_rise();
  endtask
  task automatic test_clocks(input logic s);
    int per;
    int hi;
    int exp;
    set_mode(s, 1'b0);
    per = 0;
    hi = 0;
    exp = s ? phyt_pkg::NIB_PERIOD_100_NS : phyt_pkg::NIB_PERIOD_10_NS;
    do begin
      tick();
      per++;
      hi += (tx_clk === 1'b1);
      check("rx clock", rx_clk, tx_clk);
    end while (!rose && per < 100);
    check("period", per * phyt_pkg::SYS_PERIOD_NS, exp);
    check("duty", (hi * 100 >= per * 35) && (hi * 100 <= per * 65), 1);
    $display("clock test done, speed %0d", s);
  endtask
  task automatic test_tx(input logic s, input logic f);
    logic [3:0] exp_q[$];
    int n;
    exp_q = '{4'hA, 4'h5, 4'hF};
    set_mode(s, f);
    u_mac.tx_q = exp_q;
    n = 0;
    do begin
      next_rise();
      n++;
    end while (tx_en !== 1'b1 && n < 10);
    hang(n, 10);
    foreach (exp_q[k]) begin
      check("line enable", tp_en, 1'b1);
      check("line nibble", tp_d, exp_q[k]);
      check("carrier on", crs, !f);
      next_rise();
    end
    check("line idle", tp_en, 1'b0);
    check("carrier off", crs, 1'b0);
    $display("transmit test done, speed %0d duplex %0d", s, f);
  endtask
  // line offers hold until taken; valid stays up between back-to-back nibbles
  task automatic test_rx(input logic s);
    logic [3:0] exp_q[$];
    int n;
    exp_q = '{4'h9, 4'h6, 4'hC};
    set_mode(s, 1'b1);
    u_mac.rx_q.delete();
    foreach (exp_q[k]) begin
      @(negedge line_clk);
      lv = 1'b1;
      ld = exp_q[k];
      n = 0;
      while (rdy !== 1'b1 && n < 40) begin
        @(negedge line_clk);
        n++;
      end
      hang(n, 40);
      @(posedge line_clk);
      if (k == 0) begin
        t_take = $realtime;
      end
    end
    @(negedge line_clk);
    lv = 1'b0;
    ld = ~ld;
    n = 0;
    while (u_mac.rx_q.size() < 3 && n < 400) begin
      tick();
      n++;
    end
    check("rx count", u_mac.rx_q.size(), 3);
    foreach (exp_q[k]) check("rx nibble", u_mac.rx_q[k], exp_q[k]);
    if (!s) check("rx latency", (u_mac.rx_t - t_take) <= 700.0, 1);
    $display("receive test done, speed %0d", s);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    test_clocks(1'b1);
    test_clocks(1'b0);
    test_tx(1'b1, 1'b0);
    test_tx(1'b1, 1'b1);
    test_tx(1'b0, 1'b0);
    test_rx(1'b0);
    test_rx(1'b1);
    final_report();
  end
endmodule
